/* File: rtl/pll_device_end.sv */
// pll lock, phase step, fractional feedback and output gating logic
`timescale 1ns/1ps
module pll_device_end
   import pll_ctl_pkg::*;
#(
   parameter int LOCK_CYCLES = LOCK_CYCLES_DEFAULT
)(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic sticky_lock_i,
   input wire logic bypass_i,
   input wire logic reference_valid_i,
   input wire logic feedback_valid_i,
   input wire logic [OUT_COUNT-1:0] output_active_i,
   input wire logic [SEL_W-1:0] feedback_output_i,
   input wire logic [OUT_COUNT-1:0][DIV_W-1:0] output_divider_setting_i,
   input wire logic frac_enable_i,
   input wire logic [INT_W-1:0] feedback_integer_i,
   input wire logic [FRAC_W-1:0] feedback_fraction_i,
   input wire logic spread_enable_i,
   input wire logic spread_down_i,
   input wire logic [2:0] spread_depth_code_i,
   input wire logic [3:0] spread_step_cycles_i,
   output logic [INT_W-1:0] feedback_divide_o,
   pll_link_if.device link
);

   typedef struct packed {
      lock_state_type lock_state;
      logic [LOCK_W-1:0] lock_cnt;
      logic lock_out;
      logic step_n_prev;
      logic step_pend;
      logic [STEP_CNT_W-1:0] step_cnt;
      logic [SEL_W-1:0] step_sel;
      logic step_dir;
      logic [OUT_COUNT-1:0][CNT_W-1:0] cnt;
      logic [OUT_COUNT-1:0] gate;
      logic [OUT_COUNT-1:0] clk_out;
      logic [FRAC_W-1:0] sd_acc;
      logic [INT_W-1:0] fb_div;
      logic [TRI_W-1:0] tri_pos;
      logic tri_fall;
      logic [3:0] tri_timer;
   } dev_state_type;

   dev_state_type q;
   dev_state_type d;

   // output period in ticks: eight per vco cycle times the divide ratio
   function automatic logic [CNT_W:0] tick_period(input logic [DIV_W-1:0] div);
      tick_period = {({1'b0, div} + 8'h01), 3'h0};
   endfunction

   function automatic logic [CNT_W:0] tick_half(input logic [DIV_W-1:0] div);
      tick_half = {1'b0, ({1'b0, div} + 8'h01), 2'h0};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      logic clocks_ok;
      logic fall;
      logic fire;
      logic [CNT_W:0] period;
      logic [CNT_W:0] half;
      logic [CNT_W:0] cur;
      logic [CNT_W:0] nxt;
      logic raw_now;
      logic raw_next;
      logic allowed;
      logic [2:0] code;
      logic [3:0] step_cyc;
      int span;
      int offset;
      int total;
      logic [FRAC_W:0] sum;
      clocks_ok = reference_valid_i & feedback_valid_i;
      fall = 1'b0;
      fire = 1'b0;
      period = '0;
      half = '0;
      cur = '0;
      nxt = '0;
      raw_now = 1'b0;
      raw_next = 1'b0;
      allowed = 1'b0;
      code = '0;
      step_cyc = '0;
      span = 0;
      offset = 0;
      total = 0;
      sum = '0;
      d = q;

      // lock acquisition and loss
      case (q.lock_state)
         LOCK_ACQUIRE:
         begin
            if (!clocks_ok)
               d.lock_cnt = '0;
            else if (q.lock_cnt == LOCK_W'(LOCK_CYCLES - 1))
            begin
               d.lock_state = LOCK_HELD;
               d.lock_out = 1'b1;
            end
            else
               d.lock_cnt = q.lock_cnt + 1'b1;
         end
         LOCK_HELD:
         begin
            // sticky mode ignores clock loss until the next pll reset
            if (!sticky_lock_i && !clocks_ok)
            begin
               d.lock_state = LOCK_ACQUIRE;
               d.lock_out = 1'b0;
               d.lock_cnt = '0;
            end
         end
         default:
         begin
            d.lock_state = LOCK_ACQUIRE;
            d.lock_out = 1'b0;
            d.lock_cnt = '0;
         end
      endcase

      // phase step capture; edges during the wait are not taken
      d.step_n_prev = link.shift_step_pulse_n;
      fall = q.step_n_prev & ~link.shift_step_pulse_n;
      fire = q.step_pend & (q.step_cnt == '0);
      if (q.step_pend)
      begin
         if (fire)
            d.step_pend = 1'b0;
         else
            d.step_cnt = q.step_cnt - 1'b1;
      end
      else if (fall)
      begin
         d.step_pend = 1'b1;
         d.step_cnt = STEP_CNT_W'(STEP_TICKS - 1);
         d.step_sel = link.shift_output_select;
         d.step_dir = link.shift_direction;
      end

      // output dividers, phase moves and glitchless gates
      for (int i = 0; i < OUT_COUNT; i++)
      begin
         period = tick_period(output_divider_setting_i[i]);
         half = tick_half(output_divider_setting_i[i]);
         cur = {1'b0, q.cnt[i]};
         raw_now = cur < half;
         nxt = (cur >= period - 1'b1) ? '0 : cur + 1'b1;
         if (fire && q.step_sel == SEL_W'(i) && feedback_output_i != q.step_sel)
         begin
            if (q.step_dir == DIR_DELAY)
               nxt = cur;
            else if (cur + 2'h2 >= period)
               nxt = cur + 2'h2 - period;
            else
               nxt = cur + 2'h2;
         end
         d.cnt[i] = nxt[CNT_W-1:0];
         raw_next = nxt < half;
         allowed = output_active_i[i] &
                   (link.gate_enable[i] | (feedback_output_i == SEL_W'(i)));
         if (allowed && !q.gate[i] && raw_now && !raw_next)
            d.gate[i] = 1'b1;
         else if (!allowed && !raw_next)
            d.gate[i] = 1'b0;
         d.clk_out[i] = raw_next & d.gate[i];
      end

      // triangle profile for spread spectrum
      step_cyc = spread_step_cycles_i;
      if (step_cyc < SPREAD_CYC_MIN)
         step_cyc = SPREAD_CYC_MIN;
      else if (step_cyc > SPREAD_CYC_MAX)
         step_cyc = SPREAD_CYC_MAX;
      if (!spread_enable_i)
      begin
         d.tri_pos = '0;
         d.tri_fall = 1'b0;
         d.tri_timer = '0;
      end
      else if (q.tri_timer != '0)
         d.tri_timer = q.tri_timer - 1'b1;
      else
      begin
         d.tri_timer = step_cyc - 1'b1;
         if (!q.tri_fall)
         begin
            if (q.tri_pos == TRI_W'(TRI_STEPS - 1))
               d.tri_fall = 1'b1;
            else
               d.tri_pos = q.tri_pos + 1'b1;
         end
         else if (q.tri_pos == '0)
            d.tri_fall = 1'b0;
         else
            d.tri_pos = q.tri_pos - 1'b1;
      end

      // one shared feedback divider moves every output at once
      code = (spread_depth_code_i > SPREAD_CODE_MAX) ? SPREAD_CODE_MAX : spread_depth_code_i;
      span = ((SPREAD_MIN_BP + SPREAD_STEP_BP * int'(code)) * int'(feedback_integer_i)
              * FRAC_ONE) / 10000;
      offset = (span * int'(q.tri_pos)) / TRI_STEPS;
      total = int'({feedback_integer_i, feedback_fraction_i});
      if (spread_enable_i)
         total = total - offset + (spread_down_i ? 0 : span / 2);
      if (total < 0)
         total = 0;
      if (frac_enable_i || spread_enable_i)
      begin
         sum = {1'b0, q.sd_acc} + {1'b0, total[FRAC_W-1:0]};
         d.sd_acc = sum[FRAC_W-1:0];
         d.fb_div = INT_W'(total[FRAC_W+:INT_W] + {{(INT_W-1){1'b0}}, sum[FRAC_W]});
      end
      else
      begin
         d.sd_acc = '0;
         d.fb_div = feedback_integer_i;
      end

      // bypass keeps the dividers running through a pll reset
      if (link.pll_reset)
      begin
         d.lock_state = LOCK_ACQUIRE;
         d.lock_out = 1'b0;
         d.lock_cnt = '0;
         d.step_pend = 1'b0;
         d.sd_acc = '0;
         if (!bypass_i)
         begin
            d.cnt = '0;
            d.clk_out = '0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         q <= '0;
      else if (ce_i)
         q <= d;
   end

   assign link.lock = q.lock_out;
   assign link.out_clock = q.clk_out;
   assign feedback_divide_o = q.fb_div;

endmodule // pll_device_end

/* File: rtl/pll_ctl_pkg.sv */
// shared constants and types for the pll control link and its two ends
package pll_ctl_pkg;

   localparam int CLK_HZ = 50_000_000;
   localparam int CLK_PERIOD_NS = 20;

   localparam int OUT_COUNT = 6;
   localparam int SEL_W = 3;
   localparam int DIV_W = 7;
   localparam int CNT_W = 10;
   localparam int INT_W = 8;
   localparam int FRAC_W = 12;
   localparam int FRAC_ONE = 4096;

   // one clk_i tick stands for one eighth of a vco period
   localparam int PHASES_PER_VCO = 8;
   localparam int STEP_MIN_VCO = 4;
   localparam int STEP_TICKS = PHASES_PER_VCO * STEP_MIN_VCO;
   localparam int STEP_CNT_W = 5;

   localparam int LOCK_TIME_MS = 16;
   localparam int LOCK_CYCLES_DEFAULT = LOCK_TIME_MS * (CLK_HZ / 1000);
   localparam int LOCK_W = 24;

   localparam int SETUP_TIME_NS = 5;
   localparam int SETUP_CYCLES_RAW = (SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_CYCLES = (SETUP_CYCLES_RAW < 1) ? 1 : SETUP_CYCLES_RAW;

   localparam int RST_TIME_US = 1000;
   localparam int RST_CYCLES_DEFAULT = RST_TIME_US * (CLK_HZ / 1_000_000);
   localparam int RST_W = 16;

   localparam logic DIR_DELAY = 1'h0;
   localparam logic DIR_ADVANCE = 1'h1;
   localparam logic [SEL_W-1:0] SEL_NONE = 3'h7;

   localparam int SPREAD_MIN_BP = 100;
   localparam int SPREAD_STEP_BP = 25;
   localparam logic [2:0] SPREAD_CODE_MAX = 3'h4;
   localparam int TRI_STEPS = 64;
   localparam int TRI_W = 6;
   localparam int SPREAD_FMAX_HZ = 200_000;
   localparam int SPREAD_FMIN_DHZ = 244_200;
   localparam int SPREAD_CYC_MIN_RAW = (CLK_HZ + 2 * TRI_STEPS * SPREAD_FMAX_HZ - 1)
                                       / (2 * TRI_STEPS * SPREAD_FMAX_HZ);
   localparam logic [3:0] SPREAD_CYC_MIN = 4'(SPREAD_CYC_MIN_RAW);
   localparam logic [3:0] SPREAD_CYC_MAX = 4'((CLK_HZ * 10) / (2 * TRI_STEPS * SPREAD_FMIN_DHZ));

   typedef enum logic [1:0] {
      LOCK_ACQUIRE = 2'b00,
      LOCK_HELD = 2'b01
   } lock_state_type;

   typedef enum logic [2:0] {
      CTL_IDLE = 3'b000,
      CTL_SETUP = 3'b001,
      CTL_STEP_LOW = 3'b010,
      CTL_STEP_HIGH = 3'b011,
      CTL_RESET = 3'b100
   } ctl_state_type;

endpackage

/* File: rtl/pll_link_if.sv */
// link between the pll control device end and the fabric end
`timescale 1ns/1ps
interface pll_link_if;
   import pll_ctl_pkg::*;
   logic [SEL_W-1:0] shift_output_select;
   logic shift_direction;
   logic shift_step_pulse_n;
   logic [OUT_COUNT-1:0] gate_enable;
   logic pll_reset;
   logic lock;
   logic [OUT_COUNT-1:0] out_clock;

   modport device (
      input shift_output_select,
      input shift_direction,
      input shift_step_pulse_n,
      input gate_enable,
      input pll_reset,
      output lock,
      output out_clock
   );

   modport fabric (
      output shift_output_select,
      output shift_direction,
      output shift_step_pulse_n,
      output gate_enable,
      output pll_reset,
      input lock,
      input out_clock
   );
endinterface

/* File: rtl/pll_fabric_end.sv */
// fabric-side controller driving pll phase steps, gates and reset
`timescale 1ns/1ps
module pll_fabric_end
   import pll_ctl_pkg::*;
#(
   parameter int RST_CYCLES = RST_CYCLES_DEFAULT
)(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic step_req_i,
   input wire logic [SEL_W-1:0] step_select_i,
   input wire logic step_dir_i,
   output logic step_ready_o,
   input wire logic [OUT_COUNT-1:0] enable_i,
   input wire logic auto_reset_i,
   input wire logic reset_req_i,
   output logic locked_o,
   pll_link_if.fabric link
);

   typedef struct packed {
      ctl_state_type state;
      logic [RST_W-1:0] cnt;
      logic [SEL_W-1:0] sel;
      logic dir;
      logic step_n;
      logic pll_reset;
      logic lock_prev;
      logic [OUT_COUNT-1:0] gate;
   } ctl_reg_type;

   ctl_reg_type q;
   ctl_reg_type d;

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      logic lost;
      lost = q.lock_prev & ~link.lock;
      d = q;
      d.lock_prev = link.lock;
      d.gate = enable_i;
      case (q.state)
         CTL_IDLE:
         begin
            // only one output per step, and only while locked
            if (step_req_i && link.lock)
            begin
               d.sel = step_select_i;
               d.dir = step_dir_i;
               d.cnt = RST_W'(SETUP_CYCLES - 1);
               d.state = CTL_SETUP;
            end
         end
         CTL_SETUP:
         begin
            if (q.cnt == '0)
            begin
               d.step_n = 1'b0;
               d.cnt = RST_W'(STEP_TICKS - 1);
               d.state = CTL_STEP_LOW;
            end
            else
               d.cnt = q.cnt - 1'b1;
         end
         CTL_STEP_LOW:
         begin
            if (q.cnt == '0)
            begin
               d.step_n = 1'b1;
               d.cnt = RST_W'(STEP_TICKS - 1);
               d.state = CTL_STEP_HIGH;
            end
            else
               d.cnt = q.cnt - 1'b1;
         end
         CTL_STEP_HIGH:
         begin
            // select and direction stay put until this spacing ends
            if (q.cnt == '0)
               d.state = CTL_IDLE;
            else
               d.cnt = q.cnt - 1'b1;
         end
         CTL_RESET:
         begin
            if (q.cnt == '0)
            begin
               d.pll_reset = 1'b0;
               d.state = CTL_IDLE;
            end
            else
               d.cnt = q.cnt - 1'b1;
         end
         default:
         begin
            d.state = CTL_IDLE;
            d.step_n = 1'b1;
            d.pll_reset = 1'b0;
         end
      endcase
      // a reset abandons any step; afterwards the controller waits in idle for a new request
      if (q.state != CTL_RESET && (reset_req_i || (auto_reset_i && lost)))
      begin
         d.state = CTL_RESET;
         d.pll_reset = 1'b1;
         d.step_n = 1'b1;
         d.cnt = RST_W'(RST_CYCLES - 1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         q <= '0;
         q.step_n <= 1'b1;
      end
      else if (ce_i)
         q <= d;
   end

   assign step_ready_o = (q.state == CTL_IDLE) & link.lock;
   assign locked_o = link.lock;
   assign link.shift_output_select = q.sel;
   assign link.shift_direction = q.dir;
   assign link.shift_step_pulse_n = q.step_n;
   assign link.pll_reset = q.pll_reset;
   assign link.gate_enable = q.gate;

endmodule // pll_fabric_end

/* File: verif/pll_link_props.sv */
// concurrent checks on the pll link between the fabric end and the device end
`timescale 1ns/1ps
module pll_link_props
   import pll_ctl_pkg::*;
#(
   parameter int LOCK_CYCLES = LOCK_CYCLES_DEFAULT
)(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [SEL_W-1:0] shift_output_select,
   input wire logic shift_direction,
   input wire logic shift_step_pulse_n,
   input wire logic [OUT_COUNT-1:0] gate_enable,
   input wire logic pll_reset,
   input wire logic lock,
   input wire logic [OUT_COUNT-1:0] out_clock
);
   localparam int LOCK_LIMIT = LOCK_CYCLES + 4;
   typedef struct packed {
      logic [5:0] low_run;
      logic [5:0] high_run;
   } run_type;
   run_type run_q;
   run_type run_d;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   ////////////////////////////////////////////////////////////////////////////////
   // a pll reset counts as a long idle, so a restart after it is never short
   always_comb
   begin
      run_d = run_q;
      run_d.low_run = shift_step_pulse_n ? 6'h00 : run_q.low_run + 6'h01;
      run_d.high_run = !shift_step_pulse_n ? 6'h00 :
         (pll_reset || run_q.high_run == 6'h3F) ? 6'h3F : run_q.high_run + 6'h01;
   end
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         run_q <= {6'h00, 6'h3F};
      else
         run_q <= run_d;
   end
   ////////////////////////////////////////////////////////////////////////////////
   rst_clears_a: assert property (pll_reset |=> !lock && out_clock == '0)
      else $error("lock or clocks alive during pll reset");
   lock_time_a: assert property ($fell(pll_reset) |-> !lock [*8] ##[1:LOCK_LIMIT] lock)
      else $error("lock not reached in time");
   auto_reset_a: assert property ($fell(lock) |-> ##[0:1] pll_reset)
      else $error("no pll reset after lock loss");
   sel_setup_a: assert property ($fell(shift_step_pulse_n) |->
      $stable(shift_output_select) && $stable(shift_direction))
      else $error("select or direction moved at step edge");
   sel_hold_a: assert property (!shift_step_pulse_n |=>
      $stable(shift_output_select) && $stable(shift_direction))
      else $error("select or direction moved during step");
   step_locked_a: assert property ($fell(shift_step_pulse_n) |-> $past(lock, 2))
      else $error("step issued without lock");
   low_width_a: assert property ($rose(shift_step_pulse_n) |-> run_q.low_run == 6'h20)
      else $error("step low phase not 32 ticks");
   step_space_a: assert property ($fell(shift_step_pulse_n) |-> run_q.high_run >= 6'h20)
      else $error("steps too close");
   gate_low_a: assert property (!gate_enable[1] [*8] ##1 !gate_enable[1] [*8] |->
      !out_clock[1])
      else $error("disabled clock not held low");
   step_c: cover property ($fell(shift_step_pulse_n));
   loss_c: cover property ($fell(lock) && !pll_reset);
   gate_c: cover property ($fell(gate_enable[1]));
endmodule // pll_link_props

/* File: verif/pll_lock_phase_step_control_tb.sv */
// self-checking bench joining the fabric end and the device end of the pll link
`timescale 1ns/1ps
`define CHECK(got, exp) begin checks++; if ((got) !== (exp)) begin err_total++; \
   $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp); end end
module pll_lock_phase_step_control_tb;
   import pll_ctl_pkg::*;
   localparam int LOCK_N = 20;
   logic clk_i, rst_n_i, ref_ok, fb_ok, sticky, frac_en, spr_en, spr_down;
   logic step_req, step_dir, step_ready, locked, reset_req, ce;
   logic [2:0] step_sel, spr_depth;
   logic [3:0] spr_cyc;
   logic [INT_W-1:0] fint, fdiv;
   logic [FRAC_W-1:0] ffrac;
   logic [OUT_COUNT-1:0] enable;
   wire [OUT_COUNT-1:0] oc;
   int err_total, checks;
   pll_link_if i_pll_link_if ();
   assign oc = i_pll_link_if.out_clock;
   pll_device_end #(.LOCK_CYCLES(LOCK_N)) i_pll_device_end (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .ce_i(ce), .sticky_lock_i(sticky), .bypass_i(1'b0), .reference_valid_i(ref_ok),
      .feedback_valid_i(fb_ok), .output_active_i(6'h3F), .feedback_output_i(3'h5),
      .output_divider_setting_i({OUT_COUNT{7'h01}}), .frac_enable_i(frac_en),
      .feedback_integer_i(fint), .feedback_fraction_i(ffrac), .spread_enable_i(spr_en),
      .spread_down_i(spr_down), .spread_depth_code_i(spr_depth),
      .spread_step_cycles_i(spr_cyc), .feedback_divide_o(fdiv), .link(i_pll_link_if));
   // fixed four-cycle pll reset keeps every recovery short
   pll_fabric_end #(.RST_CYCLES(4)) i_pll_fabric_end (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .ce_i(ce), .step_req_i(step_req), .step_select_i(step_sel), .step_dir_i(step_dir),
      .step_ready_o(step_ready), .enable_i(enable), .auto_reset_i(1'b1),
      .reset_req_i(reset_req), .locked_o(locked), .link(i_pll_link_if));
   pll_link_props #(.LOCK_CYCLES(LOCK_N)) i_pll_link_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .shift_output_select(i_pll_link_if.shift_output_select),
      .shift_direction(i_pll_link_if.shift_direction),
      .shift_step_pulse_n(i_pll_link_if.shift_step_pulse_n),
      .gate_enable(i_pll_link_if.gate_enable), .pll_reset(i_pll_link_if.pll_reset),
      .lock(i_pll_link_if.lock), .out_clock(i_pll_link_if.out_clock));
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic wait_lock();
      int n;
      n = 0;
      while (locked !== 1'b1 && n < LOCK_N + 12)
      begin
         @(posedge clk_i);
         n++;
      end
      `CHECK(locked, 1'b1)
   endtask
   // ticks from a rise of output c to the next rise of output b
   task automatic phase(input int b, output int p);
      logic [OUT_COUNT-1:0] prev;
      int n;
      n = -1;
      p = -1;
      prev = oc;
      repeat (48)
      begin
         @(posedge clk_i);
         if (n >= 0)
            n++;
         if (n < 0 && oc[2] && !prev[2])
            n = 0;
         if (n >= 0 && p < 0 && oc[b] && !prev[b])
            p = n;
         prev = oc;
      end
   endtask
   task automatic step(input logic [2:0] sel, input logic dir);
      int n;
      n = 0;
      while (step_ready !== 1'b1 && n < 200)
      begin
         @(posedge clk_i);
         n++;
      end
      step_req <= 1'b1;
      step_sel <= sel;
      step_dir <= dir;
      @(posedge clk_i);
      step_req <= 1'b0;
      repeat (2) @(posedge clk_i);
      n = 0;
      while (step_ready !== 1'b1 && n < 200)
      begin
         @(posedge clk_i);
         n++;
      end
      `CHECK(step_ready, 1'b1)
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_steps();
      int pb, pd, pf, q;
      phase(1, pb);
      phase(3, pd);
      phase(5, pf);
      step(3'h1, DIR_DELAY);
      step(3'h1, DIR_DELAY);
      phase(1, q);
      `CHECK(q, (pb + 2) % 16)
      phase(3, q);
      `CHECK(q, pd)
      step(3'h1, DIR_ADVANCE);
      phase(1, q);
      `CHECK(q, (pb + 1) % 16)
      step(3'h5, DIR_DELAY);
      phase(5, q);
      `CHECK(q, pf)
      $display("steps test done");
   endtask
   task automatic t_gate();
      int n, hi, fb;
      // the feedback output ignores its enable and must keep running
      enable <= 6'h1D;
      repeat (24) @(posedge clk_i);
      hi = 0;
      fb = 0;
      repeat (16)
      begin
         @(posedge clk_i);
         if (oc[1] !== 1'b0)
            hi++;
         if (oc[5] === 1'b1)
            fb++;
      end
      `CHECK(hi, 0)
      `CHECK(fb, 8)
      enable <= 6'h3F;
      n = 0;
      while (oc[1] !== 1'b1 && n < 40)
      begin
         @(posedge clk_i);
         n++;
      end
      hi = 0;
      while (oc[1] === 1'b1 && hi < 20)
      begin
         @(posedge clk_i);
         hi++;
      end
      `CHECK(hi, 8)
      $display("gate test done");
   endtask
   // a low clock enable must freeze the running outputs and the lock
   task automatic t_freeze();
      logic [OUT_COUNT-1:0] snap;
      ce <= 1'b0;
      @(posedge clk_i);
      snap = oc;
      repeat (8) @(posedge clk_i);
      `CHECK(oc, snap)
      `CHECK(locked, 1'b1)
      ce <= 1'b1;
      $display("freeze test done");
   endtask
   task automatic t_lock();
      ref_ok <= 1'b0;
      @(posedge clk_i);
      ref_ok <= 1'b1;
      repeat (2) @(posedge clk_i);
      `CHECK(locked, 1'b0)
      `CHECK(i_pll_link_if.pll_reset, 1'b1)
      wait_lock();
      sticky <= 1'b1;
      fb_ok <= 1'b0;
      repeat (3) @(posedge clk_i);
      fb_ok <= 1'b1;
      repeat (2) @(posedge clk_i);
      `CHECK(locked, 1'b1)
      reset_req <= 1'b1;
      @(posedge clk_i);
      reset_req <= 1'b0;
      repeat (3) @(posedge clk_i);
      `CHECK(locked, 1'b0)
      `CHECK(oc, 6'h00)
      wait_lock();
      $display("lock test done");
   endtask
   task automatic t_frac();
      int sum, lo, hi;
      frac_en <= 1'b1;
      fint <= 8'h10;
      ffrac <= 12'h400;
      repeat (4) @(posedge clk_i);
      sum = 0;
      repeat (FRAC_ONE)
      begin
         @(posedge clk_i);
         sum += fdiv;
      end
      `CHECK(sum, 16 * FRAC_ONE + 12'h400)
      // spread shares the fraction path, so a leftover fraction would lift the peak
      frac_en <= 1'b0;
      ffrac <= 12'h000;
      spr_en <= 1'b1;
      spr_down <= 1'b1;
      spr_depth <= 3'h4;
      spr_cyc <= 4'h2;
      repeat (4) @(posedge clk_i);
      lo = 255;
      hi = 0;
      repeat (512)
      begin
         @(posedge clk_i);
         lo = (fdiv < lo) ? fdiv : lo;
         hi = (fdiv > hi) ? fdiv : hi;
      end
      `CHECK(hi, 16)
      `CHECK(lo, 15)
      $display("fraction test done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {rst_n_i, sticky, frac_en, spr_en, spr_down, step_req, step_dir, reset_req} = '0;
      {ref_ok, fb_ok} = 2'h3;
      {step_sel, spr_depth, spr_cyc, ffrac} = '0;
      fint = 8'h10;
      enable = 6'h3F;
      ce = 1'b1;
      err_total = 0;
      checks = 0;
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      wait_lock();
      t_steps();
      t_gate();
      t_freeze();
      t_lock();
      t_frac();
      complete_run();
   end
   initial
   begin
      repeat (30000) @(posedge clk_i);
      err_total++;
      $display("MISMATCH t=%0t run hung", $time);
      complete_run();
   end
endmodule // pll_lock_phase_step_control_tb
